// *** logic/sdc_pkg.sv ***
// Shared constants for the serial display command port, both ends.
// Assumes one 20 MHz clock at each end and 8N1 framing on the link.
package sdc_pkg;
	// ==========================================
	// Clock and timing
	localparam int CLK_HZ = 20_000_000;
	localparam int CLK_NS = 50;
	localparam int BAUD_DEF = 9600;
	localparam logic [15:0] DIV_DEF = 16'(CLK_HZ / BAUD_DEF);
	localparam int RST_NS = 2000;
	localparam logic [7:0] RST_CYC = 8'((RST_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [7:0] RST_HOLD = RST_CYC + 8'h04;
	localparam int SETTLE_MS = 500;
	localparam int SETTLE_CYC = SETTLE_MS * (CLK_HZ / 1000);
	// ==========================================
	// Frame and pins
	localparam int DATA_W = 8;
	localparam int NPIN = 16;
	localparam int BUS_LO = 8;
	localparam logic [3:0] FRAME_LAST = 4'h9;
	// ==========================================
	// Bytes and commands
	localparam logic [7:0] B_ACK = 8'h06;
	localparam logic [7:0] B_NAK = 8'h15;
	localparam logic [7:0] C_AUTOBAUD = 8'h55;
	localparam logic [7:0] C_BAUD = 8'h51;
	localparam logic [7:0] C_PIN_DIR = 8'h69;
	localparam logic [7:0] C_RD_PIN = 8'h79;
	localparam logic [7:0] C_WR_PIN = 8'h59;
	localparam logic [7:0] C_RD_BUS = 8'h61;
	localparam logic [7:0] C_WR_BUS = 8'h62;
	localparam logic [7:0] N_RATES = 8'h0c;

	// Rate index to bit divisor, 600 baud up to 256K baud; index 0 (300 baud) wraps to divisor 1130
	function automatic logic [15:0] sdc_div(input logic [3:0] idx);
		int baud;
		baud = BAUD_DEF;
		case (idx)
			4'h0: baud = 300;
			4'h1: baud = 600;
			4'h2: baud = 1200;
			4'h3: baud = 2400;
			4'h4: baud = 4800;
			4'h6: baud = 19200;
			4'h7: baud = 38400;
			4'h8: baud = 57600;
			4'h9: baud = 115200;
			4'ha: baud = 128000;
			4'hb: baud = 256000;
			default: baud = BAUD_DEF;
		endcase
		return 16'(CLK_HZ / baud);
	endfunction : sdc_div
endpackage : sdc_pkg

// *** logic/sdc_link_if.sv ***
// Serial link between host and display port: two data lines and the
// open-drain master reset, pulled up here when nobody drives it low.
`timescale 1ns/1ps
interface sdc_link_if;
	logic rx_line;
	logic tx_line;
	logic mrst_o;
	logic mrst_oe;
	wire mrst_n = mrst_oe ? mrst_o : 1'b1;

	modport dev (input rx_line, input mrst_n, output tx_line);
	modport host (output rx_line, output mrst_o, output mrst_oe,
		input tx_line);
endinterface : sdc_link_if

// *** logic/sdc_dev.sv ***
// Device end of the serial display command port: UART, command parser,
// sixteen general purpose pins and master reset filter.
// Assumes the host keeps to the link framing and waits for replies.
// Operation
// - full duplex, separate lines, eight data bits
// - eight data, no parity, one stop
// - 300 to 256K baud, 9600 after reset (index 0 divisor wraps to 1130, not 300 baud)
// - start low, stop high, idle high
// - data bits sent least significant first
// - every completed command gets a reply
// - success without specific reply sends 0x06
// - failure without specific reply sends 0x15
// - unknown command byte answered with 0x15
// - replies vary in length and delay (here every reply is one byte)
// - host sends exact byte sequences
// - sixteen pins, each direction set alone
// - all pins inputs after reset
// - pins eight to fifteen form parallel bus
// - reset low over 2 us resets module
// - host drives reset open drain only
// - host waits 500 ms after reset
// - autobaud 0x55 acked before other commands
`timescale 1ns/1ps
module sdc_dev import sdc_pkg::*; (
	// Clock, reset, freeze
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	// Link
	sdc_link_if.dev link,
	// General purpose pins, upper byte is the parallel bus
	input wire logic [NPIN-1:0] gpio_i,
	output logic [NPIN-1:0] gpio_o,
	output logic [NPIN-1:0] gpio_oe,
	// Status
	output logic synced
);
	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} sdc_rx_t;
	typedef enum logic {TX_IDLE, TX_RUN} sdc_tx_t;
	typedef enum logic [1:0] {P_CMD, P_ARG, P_EXEC, P_RESP} sdc_ps_t;

	logic rx_s1, rx_s2, mr_s1, mr_s2, hit_q, srst;
	logic [NPIN-1:0] gp_s1, gp_s2;
	logic [7:0] low_q;
	logic [15:0] div_q, pend_div_q, rx_cnt_q, tx_cnt_q;
	logic pend_q, rx_vld_q, tx_q;
	sdc_rx_t rx_st_q;
	sdc_tx_t tx_st_q;
	sdc_ps_t p_st_q;
	logic [2:0] rx_bit_q;
	logic [3:0] tx_bit_q;
	logic [DATA_W-1:0] rx_sh_q, cmd_q, a0_q, a1_q, rsp_q, rsp_d;
	logic [9:0] tx_sh_q;
	logic [1:0] got_q, need_d;
	logic sync_q;
	logic [DATA_W-1:0] buf_q [2];
	logic buf_wp_q, buf_rp_q, buf_rdy, push, pop, exec;
	logic [1:0] buf_cnt_q;

	assign link.tx_line = tx_q;
	// Straight from the flop; clears the edge after internal reset starts
	assign synced = sync_q;

	// ==========================================
	// Input synchronisers and master reset filter
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rx_s1 <= 1'b1;
			rx_s2 <= 1'b1;
			mr_s1 <= 1'b1;
			mr_s2 <= 1'b1;
			gp_s1 <= '0;
			gp_s2 <= '0;
		end else if (ce) begin
			rx_s1 <= link.rx_line;
			rx_s2 <= rx_s1;
			mr_s1 <= link.mrst_n;
			mr_s2 <= mr_s1;
			gp_s1 <= gpio_i;
			gp_s2 <= gp_s1;
		end
	end

	// Glitches shorter than the limit are ignored, so a noisy pull-up
	// cannot wipe a command mid-flight
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			low_q <= 8'h00;
			hit_q <= 1'b0;
		end else if (ce) begin
			if (mr_s2)
				low_q <= 8'h00;
			else if (low_q != RST_CYC)
				low_q <= low_q + 8'h01;
			hit_q <= !mr_s2 && low_q == RST_CYC;
		end
	end
	assign srst = !rst_n || hit_q;

	// ==========================================
	// Receiver, samples mid-bit
	always_ff @(posedge clk) begin
		if (srst) begin
			rx_st_q <= RX_IDLE;
			rx_cnt_q <= 16'h0000;
			rx_bit_q <= 3'h0;
			rx_sh_q <= 8'h00;
			rx_vld_q <= 1'b0;
		end else if (ce) begin
			rx_vld_q <= 1'b0;
			if (rx_st_q != RX_IDLE && rx_cnt_q != 16'h0000) begin
				rx_cnt_q <= rx_cnt_q - 16'h0001;
			end else begin
				unique case (rx_st_q)
				RX_IDLE: if (!rx_s2) begin
					rx_st_q <= RX_START;
					rx_cnt_q <= {1'b0, div_q[15:1]};
				end
				RX_START: if (rx_s2) begin
					rx_st_q <= RX_IDLE;
				end else begin
					rx_st_q <= RX_DATA;
					rx_cnt_q <= div_q - 16'h0001;
					rx_bit_q <= 3'h0;
				end
				RX_DATA: begin
					rx_sh_q <= {rx_s2, rx_sh_q[7:1]};
					rx_cnt_q <= div_q - 16'h0001;
					rx_bit_q <= rx_bit_q + 3'h1;
					if (rx_bit_q == 3'h7)
						rx_st_q <= RX_STOP;
				end
				RX_STOP: begin
					rx_st_q <= RX_IDLE;
					rx_vld_q <= rx_s2;
				end
				endcase
			end
		end
	end

	// ==========================================
	// Two-entry reply buffer, the parser stalls while it is full
	assign buf_rdy = buf_cnt_q != 2'h2;
	assign push = p_st_q == P_RESP && buf_rdy;
	assign pop = tx_st_q == TX_IDLE && buf_cnt_q != 2'h0;
	always_ff @(posedge clk) begin
		if (srst) begin
			buf_wp_q <= 1'b0;
			buf_rp_q <= 1'b0;
			buf_cnt_q <= 2'h0;
		end else if (ce) begin
			if (push) begin
				buf_q[buf_wp_q] <= rsp_q;
				buf_wp_q <= !buf_wp_q;
			end
			if (pop)
				buf_rp_q <= !buf_rp_q;
			buf_cnt_q <= buf_cnt_q + {1'b0, push} - {1'b0, pop};
		end
	end

	// ==========================================
	// Transmitter, runs alongside the receiver
	always_ff @(posedge clk) begin
		if (srst) begin
			tx_st_q <= TX_IDLE;
			tx_q <= 1'b1;
			tx_sh_q <= 10'h3ff;
			tx_cnt_q <= 16'h0000;
			tx_bit_q <= 4'h0;
		end else if (ce) begin
			unique case (tx_st_q)
			TX_IDLE: if (pop) begin
				tx_st_q <= TX_RUN;
				tx_sh_q <= {1'b1, buf_q[buf_rp_q], 1'b0};
				tx_q <= 1'b0;
				tx_cnt_q <= div_q - 16'h0001;
				tx_bit_q <= 4'h0;
			end
			TX_RUN: if (tx_cnt_q != 16'h0000) begin
				tx_cnt_q <= tx_cnt_q - 16'h0001;
			end else if (tx_bit_q == FRAME_LAST) begin
				tx_st_q <= TX_IDLE;
			end else begin
				tx_q <= tx_sh_q[1];
				tx_sh_q <= {1'b1, tx_sh_q[9:1]};
				tx_bit_q <= tx_bit_q + 4'h1;
				tx_cnt_q <= div_q - 16'h0001;
			end
			endcase
		end
	end

	// ==========================================
	// Rate: the old rate carries the acknowledge, then the new one holds
	always_ff @(posedge clk) begin
		if (srst) begin
			div_q <= DIV_DEF;
			pend_q <= 1'b0;
			pend_div_q <= DIV_DEF;
		end else if (ce) begin
			if (exec && cmd_q == C_BAUD && a0_q < N_RATES) begin
				pend_q <= 1'b1;
				pend_div_q <= sdc_div(a0_q[3:0]);
			end else if (pend_q && p_st_q == P_CMD && buf_cnt_q == 2'h0
				&& tx_st_q == TX_IDLE && rx_st_q == RX_IDLE) begin
				pend_q <= 1'b0;
				div_q <= pend_div_q;
			end
		end
	end

	// ==========================================
	// Command parser, fields found purely by byte position
	always_comb begin
		unique case (cmd_q)
		C_BAUD, C_RD_PIN, C_WR_BUS: need_d = 2'h1;
		C_PIN_DIR, C_WR_PIN: need_d = 2'h2;
		default: need_d = 2'h0;
		endcase
	end

	assign exec = p_st_q == P_EXEC && sync_q;

	always_comb begin
		rsp_d = B_ACK;
		if (!sync_q && cmd_q != C_AUTOBAUD) begin
			rsp_d = B_NAK;
		end else begin
			unique case (cmd_q)
			C_AUTOBAUD, C_RD_BUS, C_WR_BUS: rsp_d = B_ACK;
			C_BAUD: if (a0_q >= N_RATES) rsp_d = B_NAK;
			C_PIN_DIR, C_WR_PIN: if (a0_q >= 8'(NPIN)) rsp_d = B_NAK;
			C_RD_PIN: rsp_d = a0_q >= 8'(NPIN) ? B_NAK :
				{7'h00, gp_s2[a0_q[3:0]]};
			default: rsp_d = B_NAK;
			endcase
			if (cmd_q == C_RD_BUS)
				rsp_d = gp_s2[NPIN-1:BUS_LO];
		end
	end

	// Bytes arriving while a reply is pending are dropped; the host
	// must wait for the reply before sending more
	always_ff @(posedge clk) begin
		if (srst) begin
			p_st_q <= P_CMD;
			cmd_q <= 8'h00;
			a0_q <= 8'h00;
			a1_q <= 8'h00;
			rsp_q <= B_NAK;
			got_q <= 2'h0;
			sync_q <= 1'b0;
		end else if (ce) begin
			unique case (p_st_q)
			P_CMD: if (rx_vld_q) begin
				cmd_q <= rx_sh_q;
				got_q <= 2'h0;
				p_st_q <= P_ARG;
			end
			P_ARG: begin
				if (got_q == need_d) begin
					p_st_q <= P_EXEC;
				end else if (rx_vld_q) begin
					if (got_q == 2'h0)
						a0_q <= rx_sh_q;
					else
						a1_q <= rx_sh_q;
					got_q <= got_q + 2'h1;
				end
			end
			P_EXEC: begin
				rsp_q <= rsp_d;
				if (cmd_q == C_AUTOBAUD)
					sync_q <= 1'b1;
				p_st_q <= P_RESP;
			end
			P_RESP: if (push)
				p_st_q <= P_CMD;
			endcase
		end
	end

	// ==========================================
	// Pins, one slice each
	for (genvar i = 0; i < NPIN; i++) begin : g_pin
		always_ff @(posedge clk) begin
			if (srst) begin
				gpio_o[i] <= 1'b0;
				gpio_oe[i] <= 1'b0;
			end else if (ce && exec) begin
				if (cmd_q == C_PIN_DIR && a0_q == 8'(i))
					gpio_oe[i] <= a1_q[0];
				if (cmd_q == C_WR_PIN && a0_q == 8'(i))
					gpio_o[i] <= a1_q[0];
				if (i >= BUS_LO && cmd_q == C_WR_BUS) begin
					gpio_o[i] <= a0_q[i % DATA_W];
					gpio_oe[i] <= 1'b1;
				end
				if (i >= BUS_LO && cmd_q == C_RD_BUS)
					gpio_oe[i] <= 1'b0;
			end
		end
	end
endmodule : sdc_dev

// *** logic/sdc_host.sv ***
// Host end of the serial display command port: UART, open-drain
// master reset pulse and the settle wait after any reset.
// Assumes the user side sends whole commands and awaits replies.
`timescale 1ns/1ps
module sdc_host import sdc_pkg::*; #(
	parameter int SETTLE = SETTLE_CYC
) (
	// Clock, reset, freeze
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	// Link
	sdc_link_if.host link,
	// User side
	input wire logic [3:0] baud_idx,
	input wire logic rst_req,
	input wire logic [DATA_W-1:0] tx_data,
	input wire logic tx_valid,
	output logic tx_ready,
	output logic [DATA_W-1:0] rx_data,
	output logic rx_valid,
	output logic settled
);
	typedef enum logic [1:0] {HR_IDLE, HR_START, HR_DATA, HR_STOP} sdc_hrx_t;

	logic s1, s2, tx_q, run_q, oe_q;
	logic [15:0] div, rcnt_q, tcnt_q;
	logic [9:0] sh_q;
	logic [3:0] tbit_q;
	logic [2:0] rbit_q;
	logic [7:0] hold_q;
	logic [31:0] wait_q;
	sdc_hrx_t rst_q;

	assign div = sdc_div(baud_idx);
	assign link.rx_line = tx_q;
	assign link.mrst_o = 1'b0;
	assign link.mrst_oe = oe_q;

	// ==========================================
	// Reset pulse and settle wait
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			oe_q <= 1'b0;
			hold_q <= 8'h00;
			wait_q <= 32'(SETTLE);
			settled <= 1'b0;
		end else if (ce) begin
			if (rst_req && !oe_q) begin
				oe_q <= 1'b1;
				hold_q <= RST_HOLD;
				settled <= 1'b0;
			end else if (oe_q) begin
				hold_q <= hold_q - 8'h01;
				if (hold_q == 8'h01) begin
					oe_q <= 1'b0;
					wait_q <= 32'(SETTLE);
				end
			end else if (wait_q != 32'h0) begin
				wait_q <= wait_q - 32'h1;
			end else begin
				settled <= 1'b1;
			end
		end
	end

	// ==========================================
	// Transmitter
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			tx_q <= 1'b1;
			run_q <= 1'b0;
			sh_q <= 10'h3ff;
			tcnt_q <= 16'h0000;
			tbit_q <= 4'h0;
			tx_ready <= 1'b0;
		end else if (ce) begin
			if (!run_q) begin
				tx_ready <= settled && !(tx_valid && tx_ready);
				if (tx_valid && tx_ready) begin
					run_q <= 1'b1;
					sh_q <= {1'b1, tx_data, 1'b0};
					tx_q <= 1'b0;
					tcnt_q <= div - 16'h0001;
					tbit_q <= 4'h0;
				end
			end else if (tcnt_q != 16'h0000) begin
				tcnt_q <= tcnt_q - 16'h0001;
			end else if (tbit_q == FRAME_LAST) begin
				run_q <= 1'b0;
				tx_ready <= settled;
			end else begin
				tx_q <= sh_q[1];
				sh_q <= {1'b1, sh_q[9:1]};
				tbit_q <= tbit_q + 4'h1;
				tcnt_q <= div - 16'h0001;
			end
		end
	end

	// ==========================================
	// Receiver, output gated until settled since garbage may appear
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s1 <= 1'b1;
			s2 <= 1'b1;
			rst_q <= HR_IDLE;
			rcnt_q <= 16'h0000;
			rbit_q <= 3'h0;
			rx_data <= 8'h00;
			rx_valid <= 1'b0;
		end else if (ce) begin
			s1 <= link.tx_line;
			s2 <= s1;
			rx_valid <= 1'b0;
			if (rst_q != HR_IDLE && rcnt_q != 16'h0000) begin
				rcnt_q <= rcnt_q - 16'h0001;
			end else begin
				unique case (rst_q)
				HR_IDLE: if (!s2) begin
					rst_q <= HR_START;
					rcnt_q <= {1'b0, div[15:1]};
				end
				HR_START: begin
					rst_q <= s2 ? HR_IDLE : HR_DATA;
					rcnt_q <= div - 16'h0001;
					rbit_q <= 3'h0;
				end
				HR_DATA: begin
					rx_data <= {s2, rx_data[7:1]};
					rcnt_q <= div - 16'h0001;
					rbit_q <= rbit_q + 3'h1;
					if (rbit_q == 3'h7)
						rst_q <= HR_STOP;
				end
				HR_STOP: begin
					rst_q <= HR_IDLE;
					rx_valid <= s2 && settled;
				end
				endcase
			end
		end
	end
endmodule : sdc_host

// *** tb/sdc_link_props.sv ***
// Concurrent checks on the link between host and display port ends.
// Assumes one clock and one reset shared by both ends.
`timescale 1ns/1ps
module sdc_link_props import sdc_pkg::*; #(
	parameter int SETTLE = 200
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Link
	input wire logic rx_line,
	input wire logic tx_line,
	input wire logic mrst_o,
	input wire logic mrst_oe,
	input wire logic mrst_n
);
	// ==========
	// Helpers
	// Shortest bit is 78 cycles at 256K; nine low bits at 9600, the slowest rate the bench uses, is longest
	localparam int MIN_BIT = 78;
	localparam int MAX_LOW = 18747;
	logic tx_p_q;
	logic rx_p_q;
	logic [15:0] tx_run_q;
	logic [15:0] rx_run_q;
	logic [7:0] oe_cnt_q;
	int quiet_q;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			tx_p_q <= 1'b1;
			tx_run_q <= 16'hffff;
		end else begin
			tx_p_q <= tx_line;
			if (tx_line != tx_p_q) begin
				tx_run_q <= 16'h0001;
			end else if (tx_run_q != 16'hffff) begin
				tx_run_q <= tx_run_q + 16'h0001;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rx_p_q <= 1'b1;
			rx_run_q <= 16'hffff;
		end else begin
			rx_p_q <= rx_line;
			if (rx_line != rx_p_q) begin
				rx_run_q <= 16'h0001;
			end else if (rx_run_q != 16'hffff) begin
				rx_run_q <= rx_run_q + 16'h0001;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n || !mrst_oe) begin
			oe_cnt_q <= 8'h00;
		end else begin
			oe_cnt_q <= oe_cnt_q + 8'h01;
		end
	end

	// Garbage may leave the device after reset, so the host stays quiet
	always_ff @(posedge clk) begin
		if (!rst_n || mrst_oe) begin
			quiet_q <= 0;
		end else if (quiet_q < SETTLE) begin
			quiet_q <= quiet_q + 1;
		end
	end

	// ==========
	// Assertions
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	a_rst_open_drain: assert property (mrst_oe |-> !mrst_o && !mrst_n)
		else $error("reset line not pulled low");
	a_rst_pulse_len: assert property ($fell(mrst_oe) |-> oe_cnt_q == RST_HOLD)
		else $error("reset pulse length wrong");
	a_dev_reset_idle: assert property ($fell(mrst_oe) |-> ##2 tx_line [*2])
		else $error("device line not idle after reset");
	a_tx_bit_min: assert property (tx_line != tx_p_q |-> tx_run_q >= MIN_BIT)
		else $error("device bit too short");
	a_rx_bit_min: assert property (rx_line != rx_p_q |-> rx_run_q >= MIN_BIT)
		else $error("host bit too short");
	a_tx_stop_seen: assert property (!tx_line && !tx_p_q |-> tx_run_q <= MAX_LOW)
		else $error("device frame lacks stop bit");
	a_rx_stop_seen: assert property (!rx_line && !rx_p_q |-> rx_run_q <= MAX_LOW)
		else $error("host frame lacks stop bit");
	a_settle_quiet: assert property (quiet_q < SETTLE |-> rx_line)
		else $error("host sent during settle");
endmodule : sdc_link_props

// *** tb/serial_display_command_port_bench.sv ***
// Bench joining host and device ends over one link interface.
// Assumes 20 MHz clock, host settle wait shortened to 200 cycles.
`timescale 1ns/1ps
module serial_display_command_port_bench import sdc_pkg::*;;
	// ==========
	// Signals and instances
	localparam int SETTLE_SIM = 200;
	logic clk;
	logic rst_n;
	logic ce;
	logic [NPIN-1:0] gpio_i;
	logic [NPIN-1:0] gpio_o;
	logic [NPIN-1:0] gpio_oe;
	logic synced, rst_req, tx_valid, tx_ready, rx_valid, settled;
	logic [3:0] baud_idx;
	logic [7:0] tx_data;
	logic [7:0] rx_data;
	logic [7:0] q[$];
	int fail_count;
	int n_checks;
	int cyc = 0;
	sdc_link_if link();

	sdc_dev sdc_dev_i (.clk(clk), .rst_n(rst_n), .ce(ce), .link(link),
		.gpio_i(gpio_i), .gpio_o(gpio_o), .gpio_oe(gpio_oe),
		.synced(synced));
	sdc_host #(.SETTLE(SETTLE_SIM)) sdc_host_i (.clk(clk), .rst_n(rst_n),
		.ce(ce), .link(link), .baud_idx(baud_idx), .rst_req(rst_req),
		.tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
		.rx_data(rx_data), .rx_valid(rx_valid), .settled(settled));
	sdc_link_props #(.SETTLE(SETTLE_SIM)) sdc_link_props_i (.clk(clk),
		.rst_n(rst_n), .rx_line(link.rx_line), .tx_line(link.tx_line),
		.mrst_o(link.mrst_o), .mrst_oe(link.mrst_oe), .mrst_n(link.mrst_n));

	// ==========
	// Shared tasks
	task automatic check(input string nm, input logic [15:0] e,
		input logic [15:0] g);
		n_checks++;
		if (g !== e) begin
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
			fail_count++;
		end
	endtask : check

	task automatic send(input logic [7:0] b);
		@(negedge clk);
		tx_data = b;
		tx_valid = 1'b1;
		while (tx_ready !== 1'b1) @(negedge clk);
		@(negedge clk);
		tx_valid = 1'b0;
	endtask : send

	task automatic recv(input logic [7:0] e);
		while (rx_valid !== 1'b1) @(negedge clk);
		check("reply", {8'h00, e}, {8'h00, rx_data});
	endtask : recv

	// Sends queue q whole, then waits out the full reply
	task automatic cmd(input logic [7:0] e);
		foreach (q[i]) send(q[i]);
		recv(e);
	endtask : cmd

	function automatic logic line(input logic dev);
		return dev ? link.tx_line : link.rx_line;
	endfunction : line

	// Samples each bit mid-cell at 78 cycles a bit (256K)
	task automatic frame_chk(input logic dev, input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		while (line(dev) !== 1'b0) @(negedge clk);
		repeat (39) @(negedge clk);
		for (int k = 0; k < 10; k++) begin
			check("wire", {15'h0, f[k]}, {15'h0, line(dev)});
			if (k < 9) repeat (78) @(negedge clk);
		end
	endtask : frame_chk

	task automatic stop_test;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : stop_test

	// ==========
	// Scenarios
	task automatic t_start;
		check("oe", 16'h0000, gpio_oe);
		check("tx idle", 16'h0001, {15'h0, link.tx_line});
		while (settled !== 1'b1) @(negedge clk);
		q = {C_AUTOBAUD};
		cmd(B_ACK);
		check("synced", 16'h0001, {15'h0, synced});
		$display("t_start done");
	endtask : t_start

	// Slow rates cost about 21k cycles a byte, so move to 256K early
	task automatic t_baud;
		q = {C_BAUD, 8'h0b};
		cmd(B_ACK);
		baud_idx = 4'hb;
		repeat (2000) @(negedge clk);
		q = {C_BAUD, 8'h0c};
		cmd(B_NAK);
		$display("t_baud done");
	endtask : t_baud

	task automatic t_wire;
		fork
			begin
				send(8'h2d);
				recv(B_NAK);
			end
			begin
				frame_chk(1'b0, 8'h2d);
				frame_chk(1'b1, B_NAK);
			end
		join
		$display("t_wire done");
	endtask : t_wire

	task automatic t_pins;
		q = {C_PIN_DIR, 8'h03, 8'h01};
		cmd(B_ACK);
		check("pin oe", 16'h0008, gpio_oe);
		q = {C_WR_PIN, 8'h03, 8'h01};
		cmd(B_ACK);
		check("pin out", 16'h0008, gpio_o);
		q = {C_RD_PIN, 8'h05};
		cmd(8'h01);
		$display("t_pins done");
	endtask : t_pins

	task automatic t_bus;
		q = {C_WR_BUS, 8'ha5};
		cmd(B_ACK);
		check("bus oe", 16'hff08, gpio_oe);
		check("bus out", 16'h00a5, {8'h00, gpio_o[15:8]});
		q = {C_RD_BUS};
		cmd(8'h5a);
		check("bus in", 16'h0008, gpio_oe);
		$display("t_bus done");
	endtask : t_bus

	task automatic t_mrst;
		rst_req = 1'b1;
		@(negedge clk);
		rst_req = 1'b0;
		baud_idx = 4'h5;
		repeat (60) @(negedge clk);
		check("synced", 16'h0000, {15'h0, synced});
		check("oe", 16'h0000, gpio_oe);
		check("settled", 16'h0000, {15'h0, settled});
		while (settled !== 1'b1) @(negedge clk);
		$display("t_mrst done");
	endtask : t_mrst

	// ==========
	// Clock, timeout and main sequence
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 160000) begin
			fail_count++;
			stop_test;
		end
	end

	initial begin
		rst_n = 1'b0;
		ce = 1'b1;
		gpio_i = 16'h5a20;
		baud_idx = 4'h5;
		rst_req = 1'b0;
		tx_data = 8'h00;
		tx_valid = 1'b0;
		fail_count = 0;
		n_checks = 0;
		repeat (20) @(negedge clk);
		rst_n = 1'b1;
		@(negedge clk);
		t_start;
		t_baud;
		t_wire;
		t_pins;
		t_bus;
		t_mrst;
		stop_test;
	end
endmodule : serial_display_command_port_bench
